// ==== rtl/sync_serial_slave_port.sv ====
// Synchronous slave serial port: register file, transmit path, receive path.
`timescale 1ns/1ps
module sync_serial_slave_port (
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic [3:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       we_i,
   input  wire logic       re_i,
   output logic      [7:0] rdata_o,
   input  wire logic       serial_clock_pin_i,
   output logic            serial_clock_pin_o,
   output logic            serial_clock_pin_oe_n_o,
   input  wire logic       serial_data_pin_i,
   output logic            serial_data_pin_o,
   output logic            serial_data_pin_oe_n_o,
   output logic            wake_o,
   output logic            irq_vector_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Software registers.
   //
   // Address map of the plain register port:
   //   0x0 transmit control: clock source master, nine-bit select, transmit enable,
   //       sync select, shift-empty status (read only) and the ninth transmit bit.
   //   0x1 receive control: port enable, nine-bit select, single and continuous
   //       receive, overrun status and the ninth bit of the oldest character.
   //   0x2 transmit data, write only; 0x3 receive data, read only, pops on read.
   //   0x4 global and peripheral interrupt enables.
   //   0x5 receive and transmit interrupt enables.
   //   0x6 receive and transmit flags, read only, derived from live state.
   // Flags are computed from state rather than held sticky, so software never
   // has to clear them and a stale flag cannot survive a port reset.

   logic [7:0] tx_ctl_r;
   logic [7:0] rx_ctl_r;
   logic [1:0] int_ctl_r;
   logic [1:0] irq_en_r;

   logic port_enable;
   logic active;
   logic tx_mode;
   logic rx_run;
   logic wr_tx_ctl;
   logic wr_rx_ctl;
   logic wr_tx_data;
   logic rd_rx_data;

   assign port_enable = rx_ctl_r[sync_slave_pkg::RXS_PORT_ENABLE];
   // Slave operation needs sync select set and clock source master clear.
   assign active      = port_enable
                        & tx_ctl_r[sync_slave_pkg::TXS_SYNC_SELECT]
                        & ~tx_ctl_r[sync_slave_pkg::TXS_CLOCK_SOURCE_MASTER];
   // Either receive enable selects receive mode; both clear selects transmit.
   assign tx_mode     = active & ~rx_ctl_r[sync_slave_pkg::RXS_SINGLE_RECEIVE]
                        & ~rx_ctl_r[sync_slave_pkg::RXS_CONTINUOUS_RECEIVE];
   // Only continuous receive runs the shifter; single receive is ignored here.
   assign rx_run      = active & rx_ctl_r[sync_slave_pkg::RXS_CONTINUOUS_RECEIVE];

   assign wr_tx_ctl   = we_i & (addr_i == sync_slave_pkg::ADDR_TX_STATUS_CONTROL);
   assign wr_rx_ctl   = we_i & (addr_i == sync_slave_pkg::ADDR_RX_STATUS_CONTROL);
   assign wr_tx_data  = we_i & (addr_i == sync_slave_pkg::ADDR_TRANSMIT_DATA);
   assign rd_rx_data  = re_i & (addr_i == sync_slave_pkg::ADDR_RECEIVE_DATA);

   // Control registers; status bits inside them are overlaid on read.
   // Interrupt enables keep only their two meaningful bits each.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_ctl_r  <= sync_slave_pkg::RESET_BYTE;
         rx_ctl_r  <= sync_slave_pkg::RESET_BYTE;
         int_ctl_r <= 2'h0;
         irq_en_r  <= 2'h0;
      end else begin
         if (wr_tx_ctl) begin
            tx_ctl_r <= wdata_i;
         end
         if (wr_rx_ctl) begin
            rx_ctl_r <= wdata_i;
         end
         if (we_i && addr_i == sync_slave_pkg::ADDR_INTERRUPT_CONTROL) begin
            int_ctl_r <= {wdata_i[sync_slave_pkg::INT_GLOBAL_ENABLE],
                          wdata_i[sync_slave_pkg::INT_PERIPH_ENABLE]};
         end
         if (we_i && addr_i == sync_slave_pkg::ADDR_PERIPH_IRQ_ENABLE) begin
            irq_en_r <= {wdata_i[sync_slave_pkg::PIR_RECEIVE],
                         wdata_i[sync_slave_pkg::PIR_TRANSMIT]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection.

   logic [2:0] sck_sync_r;
   logic [2:0] dt_sync_r;
   logic       sck_lvl_r;
   logic       dt_lvl_r;
   logic       sck_rise;
   logic       sck_fall;

   // Three stages per pin; a change counts once stages two and three agree.
   // Stage one feeds stage two only, so it never gates a decision.
   // An edge is seen about three system clocks after the pin moves, so each
   // half period of the link clock must span at least four system clocks.
   // The data pin shares the same latency, keeping it aligned with its clock.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sck_sync_r <= 3'h0;
         dt_sync_r  <= 3'h0;
         sck_lvl_r  <= 1'b0;
         dt_lvl_r   <= 1'b0;
      end else begin
         sck_sync_r <= {sck_sync_r[1:0], serial_clock_pin_i};
         dt_sync_r  <= {dt_sync_r[1:0], serial_data_pin_i};
         if (sck_sync_r[1] == sck_sync_r[2]) begin
            sck_lvl_r <= sck_sync_r[2];
         end
         if (dt_sync_r[1] == dt_sync_r[2]) begin
            dt_lvl_r <= dt_sync_r[2];
         end
      end
   end

   // Leading edge is the rising one, trailing the falling one.
   assign sck_rise = (sck_sync_r[1] == sck_sync_r[2]) & sck_sync_r[2] & ~sck_lvl_r;
   assign sck_fall = (sck_sync_r[1] == sck_sync_r[2]) & ~sck_sync_r[2] & sck_lvl_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Transmit path: holding register and shift register.

   // Character length from a nine-bit select.
   // Shared by both directions; each passes its own nine-bit select, so their lengths can differ.
   function automatic logic [3:0] char_bits(input logic nine);
      char_bits = nine ? sync_slave_pkg::BITS_NINE : sync_slave_pkg::BITS_EIGHT;
   endfunction : char_bits

   logic [8:0] hold_r;
   logic       hold_full_r;
   logic [8:0] tsr_r;
   logic       tsr_busy_r;
   logic [3:0] tx_cnt_r;
   logic       dt_out_r;
   logic       tx_done;
   logic       tx_load;
   logic       tx_flag;

   // The shifter ends its character on the trailing edge of the last bit.
   assign tx_done = tsr_busy_r & sck_fall
                    & (tx_cnt_r == char_bits(tx_ctl_r[sync_slave_pkg::TXS_NINE_BIT_SELECT]));
   // A held word moves as soon as the shifter is free or just finished.
   // Loading on the same cycle as done keeps back-to-back characters gapless.
   assign tx_load = hold_full_r & (~tsr_busy_r | tx_done)
                    & tx_ctl_r[sync_slave_pkg::TXS_TRANSMIT_ENABLE];

   // Holding register; the ninth bit is captured when the low byte is written.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         hold_r      <= 9'h000;
         hold_full_r <= 1'b0;
      end else if (!port_enable) begin
         hold_full_r <= 1'b0;
      end else if (wr_tx_data) begin
         hold_r      <= {tx_ctl_r[sync_slave_pkg::TXS_NINTH_BIT]
                         & tx_ctl_r[sync_slave_pkg::TXS_NINE_BIT_SELECT], wdata_i};
         hold_full_r <= 1'b1;
      end else if (tx_load) begin
         hold_full_r <= 1'b0;
      end
   end

   // Shift register: next bit goes out on each leading edge, LSB first.
   // The master samples on the trailing edge, so data has a half period to settle.
   // Limitation: the pin follows a leading edge only after the synchroniser
   // delay plus one clock, so a fast master eats into that settling time.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tsr_r      <= 9'h000;
         tsr_busy_r <= 1'b0;
         tx_cnt_r   <= 4'h0;
         dt_out_r   <= 1'b1;
      end else if (!port_enable) begin
         tsr_busy_r <= 1'b0;
         tx_cnt_r   <= 4'h0;
         dt_out_r   <= 1'b1;
      end else if (tx_load) begin
         tsr_r      <= hold_r;
         tsr_busy_r <= 1'b1;
         tx_cnt_r   <= 4'h0;
      end else if (tx_done) begin
         tsr_busy_r <= 1'b0;
      end else if (tsr_busy_r && tx_mode && sck_rise) begin
         dt_out_r <= tsr_r[0];
         tsr_r    <= {1'b0, tsr_r[8:1]};
         tx_cnt_r <= tx_cnt_r + 4'h1;
      end
   end

   // Transmit flag shows an empty holding register, only while enabled.
   // Written while transmit is disabled, a word simply waits in the holding register.
   assign tx_flag = ~hold_full_r & tx_ctl_r[sync_slave_pkg::TXS_TRANSMIT_ENABLE]
                    & port_enable;

   ////////////////////////////////////////////////////////////////////////////////
   // Receive path: shift register, two-deep buffer and overrun.

   logic [8:0] rsr_r;
   logic [3:0] rx_cnt_r;
   logic [8:0] rx_mem_r [sync_slave_pkg::RX_DEPTH];
   logic       rd_ptr_r;
   logic       wr_ptr_r;
   logic [1:0] rx_count_r;
   logic       overrun_r;
   logic       rx_done;
   logic       rx_push;
   logic       rx_pop;
   logic [8:0] rx_char;
   logic [3:0] rx_len;
   logic       rx_flag;

   assign rx_len  = char_bits(rx_ctl_r[sync_slave_pkg::RXS_NINE_BIT_SELECT]);
   // Character completes when the last bit is sampled on a trailing edge.
   assign rx_done = rx_run & ~overrun_r & sck_fall & (rx_cnt_r == rx_len - 4'h1);
   // Assemble the finished character, aligned to bit zero.
   assign rx_char = rx_ctl_r[sync_slave_pkg::RXS_NINE_BIT_SELECT]
                    ? {dt_lvl_r, rsr_r[8:1]} : {1'b0, dt_lvl_r, rsr_r[8:2]};
   // A pop in the same cycle frees a slot, so a full buffer still accepts.
   assign rx_push = rx_done & ((rx_count_r != 2'h2) | rx_pop);
   assign rx_pop  = rd_rx_data & (rx_count_r != 2'h0);

   // Receive shifter samples data on each trailing edge, LSB first.
   // Once overrun stands, nothing further is shifted in until it clears.
   // The bit counter is cleared whenever the receiver is stopped, so a frame
   // cut short by software never leaves a partial count for the next one.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rsr_r    <= 9'h000;
         rx_cnt_r <= 4'h0;
      end else if (!rx_run) begin
         rx_cnt_r <= 4'h0;
      end else if (sck_fall && !overrun_r) begin
         rsr_r    <= {dt_lvl_r, rsr_r[8:1]};
         rx_cnt_r <= rx_done ? 4'h0 : rx_cnt_r + 4'h1;
      end
   end

   // Buffer array; stored characters are never overwritten.
   // No reset on the array: the occupancy count decides what is valid.
   always_ff @(posedge clk_i) begin
      if (rx_push) begin
         rx_mem_r[wr_ptr_r] <= rx_char;
      end
   end

   // Buffer pointers and occupancy.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rd_ptr_r   <= 1'b0;
         wr_ptr_r   <= 1'b0;
         rx_count_r <= 2'h0;
      end else if (!port_enable) begin
         rd_ptr_r   <= 1'b0;
         wr_ptr_r   <= 1'b0;
         rx_count_r <= 2'h0;
      end else begin
         if (rx_push) begin
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (rx_pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         rx_count_r <= rx_count_r + {1'b0, rx_push} - {1'b0, rx_pop};
      end
   end

   // Overrun: a third whole character with the buffer full.
   // A new overrun in the same cycle as the clearing write still sets it.
   // Characters already stored stay readable while the flag stands.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         overrun_r <= 1'b0;
      end else if (rx_done && rx_count_r == 2'h2 && !rx_pop) begin
         overrun_r <= 1'b1;
      end else if (!port_enable || !rx_ctl_r[sync_slave_pkg::RXS_CONTINUOUS_RECEIVE]) begin
         overrun_r <= 1'b0;
      end
   end

   assign rx_flag = (rx_count_r != 2'h0);

   ////////////////////////////////////////////////////////////////////////////////
   // Read mux, registered so data stands in the cycle after the strobe.

   logic [8:0] rx_top;
   logic [7:0] rd_val;

   assign rx_top = (rx_count_r != 2'h0) ? rx_mem_r[rd_ptr_r] : 9'h000;

   // Status bits are overlaid on the stored control bytes.
   // Decoding is on the live address so the answer reflects state at the strobe.
   always_comb begin
      rd_val = sync_slave_pkg::RESET_BYTE;
      case (addr_i)
         sync_slave_pkg::ADDR_TX_STATUS_CONTROL: begin
            rd_val = tx_ctl_r;
            rd_val[sync_slave_pkg::TXS_SHIFT_EMPTY] = ~tsr_busy_r;
         end
         sync_slave_pkg::ADDR_RX_STATUS_CONTROL: begin
            rd_val = rx_ctl_r;
            rd_val[3:2] = 2'h0;
            rd_val[sync_slave_pkg::RXS_OVERRUN]   = overrun_r;
            rd_val[sync_slave_pkg::RXS_NINTH_BIT] = rx_top[8];
         end
         sync_slave_pkg::ADDR_RECEIVE_DATA: begin
            rd_val = rx_top[7:0];
         end
         sync_slave_pkg::ADDR_INTERRUPT_CONTROL: begin
            rd_val[sync_slave_pkg::INT_GLOBAL_ENABLE] = int_ctl_r[1];
            rd_val[sync_slave_pkg::INT_PERIPH_ENABLE] = int_ctl_r[0];
         end
         sync_slave_pkg::ADDR_PERIPH_IRQ_ENABLE: begin
            rd_val[sync_slave_pkg::PIR_RECEIVE]  = irq_en_r[1];
            rd_val[sync_slave_pkg::PIR_TRANSMIT] = irq_en_r[0];
         end
         sync_slave_pkg::ADDR_PERIPH_IRQ_FLAGS: begin
            rd_val[sync_slave_pkg::PIR_RECEIVE]  = rx_flag;
            rd_val[sync_slave_pkg::PIR_TRANSMIT] = tx_flag;
         end
         default: begin
            rd_val = sync_slave_pkg::RESET_BYTE;
         end
      endcase
   end

   // Read data register; holds zero on cycles without a read strobe.
   // Returning zero outside a read keeps the bus quiet for wired-or sharing.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o <= sync_slave_pkg::RESET_BYTE;
      end else begin
         rdata_o <= re_i ? rd_val : sync_slave_pkg::RESET_BYTE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Wake and vector outputs, registered.

   logic irq_pending;

   // A flag counts only when its own enable is set.
   assign irq_pending = (tx_flag & irq_en_r[0]) | (rx_flag & irq_en_r[1]);

   // Wake needs no global enable, so Sleep is left by any enabled flag while the peripheral enable is set.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wake_o       <= 1'b0;
         irq_vector_o <= 1'b0;
      end else begin
         wake_o       <= int_ctl_r[0] & irq_pending;
         irq_vector_o <= int_ctl_r[1] & int_ctl_r[0] & irq_pending;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin drivers.

   // The clock pin is an input only in slave mode.
   // Master mode is outside this block, so the clock driver stays off always.
   assign serial_clock_pin_o      = 1'b0;
   assign serial_clock_pin_oe_n_o = 1'b1;
   // Data is driven only in slave transmit mode; master timing is relied upon.
   // Outside transmit mode the line is released to the far end.
   assign serial_data_pin_o       = dt_out_r;
   assign serial_data_pin_oe_n_o  = ~tx_mode;

endmodule : sync_serial_slave_port

// ==== rtl/sync_slave_pkg.sv ====
// Constants shared by the synchronous slave serial port.
package sync_slave_pkg;
   // Register addresses on the plain register port.
   localparam logic [3:0] ADDR_TX_STATUS_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_RX_STATUS_CONTROL = 4'h1;
   localparam logic [3:0] ADDR_TRANSMIT_DATA     = 4'h2;
   localparam logic [3:0] ADDR_RECEIVE_DATA      = 4'h3;
   localparam logic [3:0] ADDR_INTERRUPT_CONTROL = 4'h4;
   localparam logic [3:0] ADDR_PERIPH_IRQ_ENABLE = 4'h5;
   localparam logic [3:0] ADDR_PERIPH_IRQ_FLAGS  = 4'h6;
   // Transmit status and control fields.
   localparam int TXS_CLOCK_SOURCE_MASTER = 7;
   localparam int TXS_NINE_BIT_SELECT     = 6;
   localparam int TXS_TRANSMIT_ENABLE     = 5;
   localparam int TXS_SYNC_SELECT         = 4;
   localparam int TXS_SHIFT_EMPTY         = 1;
   localparam int TXS_NINTH_BIT           = 0;
   // Receive status and control fields.
   localparam int RXS_PORT_ENABLE         = 7;
   localparam int RXS_NINE_BIT_SELECT     = 6;
   localparam int RXS_SINGLE_RECEIVE      = 5;
   localparam int RXS_CONTINUOUS_RECEIVE  = 4;
   localparam int RXS_OVERRUN             = 1;
   localparam int RXS_NINTH_BIT           = 0;
   // Interrupt control, enable and flag fields.
   localparam int INT_GLOBAL_ENABLE       = 7;
   localparam int INT_PERIPH_ENABLE       = 6;
   localparam int PIR_RECEIVE             = 5;
   localparam int PIR_TRANSMIT            = 4;
   // Reset values, character lengths and receive buffer depth.
   localparam logic [7:0] RESET_BYTE      = 8'h00;
   localparam logic [3:0] BITS_EIGHT      = 4'h8;
   localparam logic [3:0] BITS_NINE       = 4'h9;
   localparam int         RX_DEPTH        = 2;
endpackage : sync_slave_pkg

// ==== tb/serial_master_model.sv ====
// External synchronous master that clocks frames into and out of the slave port.
`timescale 1ns/1ps
module serial_master_model (
   input  wire logic data_i,
   output logic      sck_o,
   output logic      dat_o
);
   // The clock stands low between frames.
   initial begin
      sck_o = 1'b0;
      dat_o = 1'b1;
   end
   // One 200 ns clock per bit; data moves on the leading edge, sampled on the trailing.
   task automatic frame(input int n, input logic [8:0] tx, output logic [8:0] rx);
      rx = 9'h000;
      for (int i = 0; i < n; i++) begin
         sck_o = 1'b1;
         dat_o = tx[i];
         #100;
         sck_o = 1'b0;
         rx[i] = data_i;
         #100;
      end
      // Invert once released so a stale bit is never taken for fresh data.
      dat_o = ~dat_o;
   endtask : frame
endmodule : serial_master_model

// ==== tb/serial_slave_props.sv ====
// Concurrent checks on the ports of the synchronous slave serial port.
`timescale 1ns/1ps
module serial_slave_props (
   input wire logic       clk_i,
   input wire logic       resetn_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic       we_i,
   input wire logic       re_i,
   input wire logic [7:0] rdata_o,
   input wire logic       serial_clock_pin_oe_n_o,
   input wire logic       serial_data_pin_oe_n_o,
   input wire logic       wake_o,
   input wire logic       irq_vector_o
);
   logic [7:0] tx_sh;
   logic [7:0] rx_sh;
   logic [7:0] ic_sh;
   logic       pe;
   logic       live;
   logic       peripheral_irq_enable;
   logic       global_irq_enable;
   logic       tmode;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   ////////////////////////////////////////////////////////////////////////////
   // Shadow copies of the control registers, taken from the write strobe.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_sh <= 8'h00;
         rx_sh <= 8'h00;
         ic_sh <= 8'h00;
      end else if (we_i) begin
         if (addr_i == sync_slave_pkg::ADDR_TX_STATUS_CONTROL) tx_sh <= wdata_i;
         if (addr_i == sync_slave_pkg::ADDR_RX_STATUS_CONTROL) rx_sh <= wdata_i;
         if (addr_i == sync_slave_pkg::ADDR_INTERRUPT_CONTROL) ic_sh <= wdata_i;
      end
   end
   // Derived modes; the data pin direction must follow these with no delay.
   assign pe    = rx_sh[sync_slave_pkg::RXS_PORT_ENABLE];
   assign live  = pe & rx_sh[sync_slave_pkg::RXS_CONTINUOUS_RECEIVE];
   assign peripheral_irq_enable  = ic_sh[sync_slave_pkg::INT_PERIPH_ENABLE];
   assign global_irq_enable   = ic_sh[sync_slave_pkg::INT_GLOBAL_ENABLE];
   assign tmode = pe & tx_sh[sync_slave_pkg::TXS_SYNC_SELECT]
                  & ~tx_sh[sync_slave_pkg::TXS_CLOCK_SOURCE_MASTER]
                  & ~rx_sh[sync_slave_pkg::RXS_SINGLE_RECEIVE]
                  & ~rx_sh[sync_slave_pkg::RXS_CONTINUOUS_RECEIVE];
   ////////////////////////////////////////////////////////////////////////////
   a_clock_released: assert property (serial_clock_pin_oe_n_o == 1'b1)
      else $error("clock pin driven by slave");
   a_data_direction: assert property (serial_data_pin_oe_n_o == !tmode)
      else $error("data pin direction wrong for mode");
   a_disabled_quiet: assert property (!pe |-> serial_data_pin_oe_n_o)
      else $error("data pin driven while port disabled");
   a_wake_gated: assert property (!$past(peripheral_irq_enable) |-> !wake_o)
      else $error("wake without peripheral enable");
   a_vector_wake: assert property (irq_vector_o |-> wake_o)
      else $error("vector without wake");
   a_vector_global: assert property (!$past(global_irq_enable) |-> !irq_vector_o)
      else $error("vector without global enable");
   a_overrun_clear: assert property (re_i && addr_i == 4'h1 && !live && !$past(live)
      |=> !rdata_o[sync_slave_pkg::RXS_OVERRUN])
      else $error("overrun survives clearing");
   a_rdata_idle: assert property (!re_i |=> rdata_o == 8'h00)
      else $error("read data outside read slot");
endmodule : serial_slave_props

bind sync_serial_slave_port serial_slave_props u_props (.clk_i(clk_i), .resetn_i(resetn_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
   .serial_clock_pin_oe_n_o(serial_clock_pin_oe_n_o),
   .serial_data_pin_oe_n_o(serial_data_pin_oe_n_o), .wake_o(wake_o),
   .irq_vector_o(irq_vector_o));

// ==== tb/testbench.sv ====
// Self-checking bench for the synchronous slave serial port.
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_count++; \
   $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
   logic       clk_i    = 1'b0;
   logic       resetn_i = 1'b0;
   logic [3:0] addr_i   = 4'h0;
   logic [7:0] wdata_i  = 8'h00;
   logic       we_i     = 1'b0;
   logic       re_i     = 1'b0;
   logic       rd_d     = 1'b0;
   logic [7:0] rdata_o;
   logic       sck, cko, cko_n, dout, doe_n, mdat, dwire, wake_o, irq_vector_o;
   logic [7:0] expq[$];
   logic [7:0] b0, b1;
   logic [8:0] rx;
   logic [8:0] c[3];
   logic [3:0] ra[6] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'hf};
   int         err_count   = 0;
   int         check_count = 0;
   int         seed        = 46762;
   // The data wire follows whoever drives it.
   assign dwire = !doe_n ? dout : mdat;
   always #12.5 clk_i = ~clk_i;
   sync_serial_slave_port DUT (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
      .serial_clock_pin_i(sck), .serial_clock_pin_o(cko), .serial_clock_pin_oe_n_o(cko_n),
      .serial_data_pin_i(dwire), .serial_data_pin_o(dout), .serial_data_pin_oe_n_o(doe_n),
      .wake_o(wake_o), .irq_vector_o(irq_vector_o));
   serial_master_model m (.data_i(dwire), .sck_o(sck), .dat_o(mdat));
   ////////////////////////////////////////////////////////////////////////////
   // Read data stand only in the cycle after the strobe, so compare there.
   always @(posedge clk_i) begin
      if (rd_d) `CHK(rdata_o, expq.pop_front())
      rd_d <= re_i;
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      addr_i  <= a;
      wdata_i <= d;
      we_i    <= 1'b1;
      re_i    <= 1'b0;
      @(posedge clk_i);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      addr_i <= a;
      we_i   <= 1'b0;
      re_i   <= 1'b1;
      expq.push_back(e);
      @(posedge clk_i);
   endtask : rd
   task automatic idle();
      we_i <= 1'b0;
      re_i <= 1'b0;
      @(posedge clk_i);
   endtask : idle
   // Bounded wait for the wake output; a lapse counts as a mismatch and the run goes on.
   task automatic wait_wake();
      int n;
      n = 0;
      while (wake_o !== 1'b1 && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      `CHK(wake_o, 1'b1)
   endtask : wait_wake
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : finish_test
   initial begin
      #2000000;
      err_count++;
      finish_test();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      // After reset the idle transmit shifter reads as empty in its status bit.
      foreach (ra[i]) rd(ra[i], (ra[i] == sync_slave_pkg::ADDR_TX_STATUS_CONTROL)
         ? 8'(1 << sync_slave_pkg::TXS_SHIFT_EMPTY) : sync_slave_pkg::RESET_BYTE);
      b0 = 8'($random(seed));
      b1 = 8'($random(seed));
      // Two words queued for transmit; the second must wait with the flag clear.
      wr(4'h4, 8'h40);
      wr(4'h5, 8'h10);
      wr(4'h1, 8'h80);
      wr(4'h0, 8'h30);
      wr(4'h2, b0);
      idle();
      idle();
      wr(4'h2, b1);
      idle();
      rd(4'h6, 8'h00);
      idle();
      `CHK(wake_o, 1'b0)
      `CHK({cko, cko_n}, 2'h1)
      #7 m.frame(8, 9'h1ff, rx);
      `CHK(rx[7:0], b0)
      @(posedge clk_i);
      wait_wake();
      `CHK(irq_vector_o, 1'b0)
      rd(4'h6, 8'h10);
      idle();
      #7 m.frame(8, 9'h0aa, rx);
      `CHK(rx[7:0], b1)
      // Nine-bit character; the ninth bit travels last.
      @(posedge clk_i);
      wr(4'h0, 8'h71);
      wr(4'h2, b0);
      idle();
      idle();
      #7 m.frame(9, 9'h000, rx);
      `CHK(rx, {1'b1, b0})
      // Three nine-bit characters into a two-deep buffer force an overrun.
      @(posedge clk_i);
      wr(4'h0, 8'h10);
      wr(4'h5, 8'h20);
      wr(4'h4, 8'hc0);
      wr(4'h1, 8'hd0);
      idle();
      foreach (c[k]) begin
         c[k] = 9'($random(seed));
         #3 m.frame(9, c[k], rx);
      end
      @(posedge clk_i);
      wait_wake();
      `CHK(irq_vector_o, 1'b1)
      rd(4'h6, 8'h20);
      rd(4'h1, {7'h69, c[0][8]});
      rd(4'h3, c[0][7:0]);
      rd(4'h1, {7'h69, c[1][8]});
      rd(4'h3, c[1][7:0]);
      rd(4'h6, 8'h00);
      rd(4'h3, 8'h00);
      wr(4'h1, 8'hc0);
      idle();
      rd(4'h1, 8'hc0);
      // Single receive alone must not start the receiver.
      wr(4'h1, 8'ha0);
      idle();
      m.frame(8, 9'($random(seed)), rx);
      @(posedge clk_i);
      repeat (8) idle();
      rd(4'h6, 8'h00);
      wr(4'h1, 8'h00);
      idle();
      rd(4'h1, 8'h00);
      idle();
      idle();
      finish_test();
   end
endmodule : testbench
